/* logic/dil_pkg.sv */
package dil_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CH1_ACTIVE_IDX  = 8'h3B;
  localparam logic [7:0] CH0_ACTIVE_IDX  = 8'h38;
  localparam logic [7:0] SW_TRIGGER_IDX  = 8'h45;
  localparam logic [7:0] CH0_STAGING_IDX = 8'h46;
  localparam logic [7:0] CH1_STAGING_IDX = 8'h49;
  localparam logic [7:0] AUTO_CTRL_IDX   = 8'h4C;
  // Field layout
  localparam int CODE_LSB      = 8;
  localparam int CODE_W        = 16;
  localparam int LOAD_CH0_BIT  = 0;
  localparam int LOAD_CH1_BIT  = 1;
  localparam int AUTO_EN_BIT   = 0;
  // Reset values
  localparam logic [15:0] CODE_RESET    = 16'h0000;
  localparam logic        AUTO_EN_RESET = 1'b0;
  localparam logic        LINE_IDLE     = 1'b1;
  // Wishbone word addressing
  localparam int ADDR_W        = 10;
  localparam int WORD_SHIFT    = 2;
endpackage

/* logic/dil_channel.sv */
`timescale 1ns/10ps
// One channel: staging code written by software, active code loaded on a trigger
module dil_channel #(
  parameter int          W     = 16,
  parameter logic [15:0] RST_V = 16'h0000
) (
  input  wire logic         mclk,
  input  wire logic         rstSyncN,
  input  wire logic         stageWe,
  input  wire logic [1:0]   stageBe,
  input  wire logic [W-1:0] stageData,
  input  wire logic         load,
  output logic      [W-1:0] stagedCode,
  output logic      [W-1:0] activeCode
);
  logic [W-1:0] staged_reg;
  logic [W-1:0] staged_next;
  logic [W-1:0] active_reg;
  logic [W-1:0] active_next;

  // Byte-lane write to staging; load copies the value held before this edge
  always_comb begin
    staged_next = staged_reg;
    active_next = active_reg;
    if (stageWe && stageBe[0]) begin
      staged_next[7:0] = stageData[7:0];
    end
    if (stageWe && stageBe[1]) begin
      staged_next[W-1:8] = stageData[W-1:8];
    end
    if (load) begin
      active_next = staged_reg; // R4
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      staged_reg <= RST_V[W-1:0];
      active_reg <= RST_V[W-1:0];
    end else begin
      staged_reg <= staged_next;
      active_reg <= active_next;
    end
  end

  assign stagedCode = staged_reg;
  assign activeCode = active_reg;
endmodule

/* logic/dil_top.sv */
`timescale 1ns/10ps
// What this block does
// [R1] Writing 1 to channel 1 load bit copies its staging to active code.
// [R2] Writing 1 to channel 0 load bit copies its staging to active code.
// [R3] Load bits are write-only at bits 1 and 0 and self-clear.
// [R4] Active code loads from staging on hardware line, software bit or auto.
// [R5] Channel 0 staging holds 16-bit code in 23:8; low byte reads zero.
// [R6] Channel 1 staging holds 16-bit code in 23:8; low byte reads zero.
// [R7] Internal reset held until both supply rails report good.
// [R8] Pulling the hardware load line low loads both channels, like writing both load bits.
// [R9] Both load bits in one write update both channels same cycle.
module dil_top (
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic                    avddGood,
  input  wire logic                    dvddGood,
  input  wire logic                    hwLoadLineN,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [dil_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output logic      [15:0]             ch0ActiveCode,
  output logic      [15:0]             ch1ActiveCode
);
  logic        rawRstN;
  logic [1:0]  rstSync_reg;
  logic        rstSyncN;
  logic [2:0]  lineSync_reg;
  logic        lineState_reg;
  logic        lineState_next;
  logic        hwFall;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic        autoEn_reg;
  logic        autoEn_next;
  logic [1:0]  autoPend_reg;
  logic [1:0]  autoPend_next;
  logic        wrStrobe;
  logic [7:0]  regIdx;
  logic        trigWr;
  logic        st0We;
  logic        st1We;
  logic        load0;
  logic        load1;
  logic [15:0] staged0;
  logic [15:0] staged1;

  // Supply monitor gates reset; release is synchronised so it never lands mid-edge
  assign rawRstN = rstn & avddGood & dvddGood; // R7

  always_ff @(posedge mclk or negedge rawRstN) begin
    if (!rawRstN) begin
      rstSync_reg <= 2'b00;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync_reg[1];

  // Load pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lineSync_reg <= {3{dil_pkg::LINE_IDLE}};
    end else begin
      lineSync_reg <= {lineSync_reg[1:0], hwLoadLineN};
    end
  end

  // Falling edge of the filtered line is the hardware trigger
  always_comb begin
    lineState_next = lineState_reg;
    if (lineSync_reg[1] == lineSync_reg[2]) begin
      lineState_next = lineSync_reg[2];
    end
  end
  assign hwFall = lineState_reg & ~lineState_next;

  // Wishbone decode; a write takes effect at the edge where ack is high
  assign regIdx   = wb_adr_i[dil_pkg::ADDR_W-1:dil_pkg::WORD_SHIFT];
  assign wrStrobe = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  assign trigWr   = wrStrobe && regIdx == dil_pkg::SW_TRIGGER_IDX && wb_sel_i[0];
  assign st0We    = wrStrobe && regIdx == dil_pkg::CH0_STAGING_IDX;
  assign st1We    = wrStrobe && regIdx == dil_pkg::CH1_STAGING_IDX;

  // Writing 0 to a load bit does nothing; bits are never stored, so they self-clear
  assign load0 = (trigWr & wb_dat_i[dil_pkg::LOAD_CH0_BIT]) | hwFall | autoPend_reg[0]; // R2 R8
  assign load1 = (trigWr & wb_dat_i[dil_pkg::LOAD_CH1_BIT]) | hwFall | autoPend_reg[1]; // R1 R8 R9

  // Bus answer, read mux and auto-transfer control
  always_comb begin
    ack_next      = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdat_next     = 32'h0000_0000;
    autoEn_next   = autoEn_reg;
    autoPend_next = {st1We & autoEn_reg, st0We & autoEn_reg}; // R4
    unique case (regIdx)
      dil_pkg::CH0_STAGING_IDX: rdat_next[23:8] = staged0; // R5
      dil_pkg::CH1_STAGING_IDX: rdat_next[23:8] = staged1; // R6
      dil_pkg::CH0_ACTIVE_IDX:  rdat_next[23:8] = ch0ActiveCode;
      dil_pkg::CH1_ACTIVE_IDX:  rdat_next[23:8] = ch1ActiveCode;
      dil_pkg::AUTO_CTRL_IDX:   rdat_next[dil_pkg::AUTO_EN_BIT] = autoEn_reg;
      default:                  rdat_next = 32'h0000_0000; // Trigger reads zero, R3
    endcase
    if (wrStrobe && regIdx == dil_pkg::AUTO_CTRL_IDX && wb_sel_i[0]) begin
      autoEn_next = wb_dat_i[dil_pkg::AUTO_EN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ack_reg       <= 1'b0;
      rdat_reg      <= 32'h0000_0000;
      autoEn_reg    <= dil_pkg::AUTO_EN_RESET;
      autoPend_reg  <= 2'b00;
      lineState_reg <= dil_pkg::LINE_IDLE;
    end else begin
      ack_reg       <= ack_next;
      rdat_reg      <= rdat_next;
      autoEn_reg    <= autoEn_next;
      autoPend_reg  <= autoPend_next;
      lineState_reg <= lineState_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Channel slices; staging byte lanes follow sel bits 1 and 2
  dil_channel #(.W(dil_pkg::CODE_W), .RST_V(dil_pkg::CODE_RESET)) uCh0 (
    .mclk       (mclk),
    .rstSyncN   (rstSyncN),
    .stageWe    (st0We),
    .stageBe    (wb_sel_i[2:1]),
    .stageData  (wb_dat_i[23:8]),
    .load       (load0),
    .stagedCode (staged0),
    .activeCode (ch0ActiveCode)
  );

  dil_channel #(.W(dil_pkg::CODE_W), .RST_V(dil_pkg::CODE_RESET)) uCh1 (
    .mclk       (mclk),
    .rstSyncN   (rstSyncN),
    .stageWe    (st1We),
    .stageBe    (wb_sel_i[2:1]),
    .stageData  (wb_dat_i[23:8]),
    .load       (load1),
    .stagedCode (staged1),
    .activeCode (ch1ActiveCode)
  );

  // Checks
  property p_swLoad1;
    @(posedge mclk) disable iff (!rstSyncN)
    (trigWr && wb_dat_i[1]) |=> ch1ActiveCode == $past(staged1);
  endproperty
  a_swLoad1: assert property (p_swLoad1) else $error("ch1 load missed"); // R1

  property p_swLoad0;
    @(posedge mclk) disable iff (!rstSyncN)
    (trigWr && wb_dat_i[0]) |=> ch0ActiveCode == $past(staged0);
  endproperty
  a_swLoad0: assert property (p_swLoad0) else $error("ch0 load missed"); // R2

  property p_trigReadsZero;
    @(posedge mclk) disable iff (!rstSyncN)
    (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg && regIdx == dil_pkg::SW_TRIGGER_IDX)
      |=> wb_ack_o && wb_dat_o == 32'h0000_0000;
  endproperty
  a_trigReadsZero: assert property (p_trigReadsZero) else $error("trigger not zero"); // R3

  property p_noTrigHold;
    @(posedge mclk) disable iff (!rstSyncN)
    !load0 |=> $stable(ch0ActiveCode);
  endproperty
  a_noTrigHold: assert property (p_noTrigHold) else $error("ch0 moved unbid"); // R4

  property p_resv0;
    @(posedge mclk) disable iff (!rstSyncN)
    (ack_next && regIdx == dil_pkg::CH0_STAGING_IDX) |=> wb_dat_o[7:0] == 8'h00
      && wb_dat_o[23:8] == $past(staged0);
  endproperty
  a_resv0: assert property (p_resv0) else $error("ch0 staging read bad"); // R5

  property p_resv1;
    @(posedge mclk) disable iff (!rstSyncN)
    (ack_next && regIdx == dil_pkg::CH1_STAGING_IDX) |=> wb_dat_o[7:0] == 8'h00
      && wb_dat_o[23:8] == $past(staged1);
  endproperty
  a_resv1: assert property (p_resv1) else $error("ch1 staging read bad"); // R6

  property p_supplyReset;
    @(posedge mclk) (!avddGood || !dvddGood) |=> !rstSyncN;
  endproperty
  a_supplyReset: assert property (p_supplyReset) else $error("reset not held"); // R7

  property p_hwLoad;
    @(posedge mclk) disable iff (!rstSyncN)
    hwFall |=> ch0ActiveCode == $past(staged0) && ch1ActiveCode == $past(staged1);
  endproperty
  a_hwLoad: assert property (p_hwLoad) else $error("hw load missed"); // R8

  // Judged on the codes themselves, so a broken slice load still trips it
  property p_bothLoad;
    @(posedge mclk) disable iff (!rstSyncN)
    (trigWr && wb_dat_i[1:0] == 2'b11)
      |=> ch0ActiveCode == $past(staged0) && ch1ActiveCode == $past(staged1);
  endproperty
  a_bothLoad: assert property (p_bothLoad) else $error("loads split"); // R9

  // Auto transfer lands one edge after the staging write, with the new code
  property p_autoLoad0;
    @(posedge mclk) disable iff (!rstSyncN)
    (st0We && autoEn_reg) |=> ##1 ch0ActiveCode == $past(staged0);
  endproperty
  a_autoLoad0: assert property (p_autoLoad0) else $error("ch0 auto load missed"); // R4

  c_swBoth: cover property (@(posedge mclk) trigWr && wb_dat_i[1:0] == 2'b11);
  c_hwFall: cover property (@(posedge mclk) hwFall);
  c_auto:   cover property (@(posedge mclk) |autoPend_reg);
endmodule

/* test/dil_testbench.sv */
`timescale 1ns/10ps
// Drives the register bus, the load line and both rail monitors
module testbench;
  logic        mclk;
  logic        rstn;
  logic        avddGood;
  logic        dvddGood;
  logic        hwLoadLineN;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [9:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic [15:0] ch0ActiveCode;
  logic [15:0] ch1ActiveCode;
  logic [15:0] c0AtAck;
  logic [15:0] c1AtAck;
  int          mismatches = 0;
  int          total_checks = 0;

  dil_top i_dil_top (.mclk(mclk), .rstn(rstn), .avddGood(avddGood), .dvddGood(dvddGood),
    .hwLoadLineN(hwLoadLineN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .ch0ActiveCode(ch0ActiveCode), .ch1ActiveCode(ch1ActiveCode));

  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One classic cycle; read data and codes are taken at the ack edge
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] wd,
                      input logic [3:0] sel, output logic [31:0] rd);
    int n;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbSel <= sel;
    wbDatI <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (wbAck === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      $display("MISMATCH %0t no ack", $time);
      stop_test();
    end else begin
      rd = wbDatO;
      c0AtAck = ch0ActiveCode;
      c1AtAck = ch1ActiveCode;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, idx, d, 4'hF, rd);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string msg);
    logic [31:0] rd;
    xfer(1'b0, idx, 32'h0000_0000, 4'hF, rd);
    chk(rd, exp, msg);
  endtask

  task automatic codes(input logic [15:0] e0, input logic [15:0] e1);
    chk({16'h0000, ch0ActiveCode}, {16'h0000, e0}, "ch0 active");
    chk({16'h0000, ch1ActiveCode}, {16'h0000, e1}, "ch1 active");
  endtask

  task automatic t_stage();
    rdchk(dil_pkg::CH0_STAGING_IDX, 32'h0000_0000, "ch0 reset");
    rdchk(dil_pkg::CH1_STAGING_IDX, 32'h0000_0000, "ch1 reset");
    codes(16'h0000, 16'h0000);
    wr(dil_pkg::CH0_STAGING_IDX, 32'hFFFF_FFFF);
    wr(dil_pkg::CH1_STAGING_IDX, 32'h00A5_C3FF);
    wr(8'h10, 32'hFFFF_FFFF);
    rdchk(dil_pkg::CH0_STAGING_IDX, 32'h00FF_FF00, "ch0 code");
    rdchk(dil_pkg::CH1_STAGING_IDX, 32'h00A5_C300, "ch1 code");
    rdchk(8'h10, 32'h0000_0000, "unmapped");
    codes(16'h0000, 16'h0000);
    $display("t_stage done");
  endtask

  task automatic t_swload();
    wr(dil_pkg::SW_TRIGGER_IDX, 32'h0000_0000);
    codes(16'h0000, 16'h0000);
    wr(dil_pkg::SW_TRIGGER_IDX, 32'h0000_0001);
    codes(16'hFFFF, 16'h0000);
    wr(dil_pkg::SW_TRIGGER_IDX, 32'h0000_0002);
    codes(16'hFFFF, 16'hA5C3);
    rdchk(dil_pkg::SW_TRIGGER_IDX, 32'h0000_0000, "trigger reads");
    $display("t_swload done");
  endtask

  task automatic t_both();
    wr(dil_pkg::CH0_STAGING_IDX, 32'h0012_3400);
    wr(dil_pkg::CH1_STAGING_IDX, 32'h0056_7800);
    wr(dil_pkg::SW_TRIGGER_IDX, 32'h0000_00FF);
    chk({c0AtAck, c1AtAck}, 32'hFFFF_A5C3, "old at ack");
    codes(16'h1234, 16'h5678);
    $display("t_both done");
  endtask

  task automatic t_hw();
    wr(dil_pkg::CH0_STAGING_IDX, 32'h000F_0F00);
    wr(dil_pkg::CH1_STAGING_IDX, 32'h00F0_F000);
    hwLoadLineN <= 1'b0;
    repeat (5) @(posedge mclk);
    hwLoadLineN <= 1'b1;
    repeat (8) @(posedge mclk);
    codes(16'h0F0F, 16'hF0F0);
    $display("t_hw done");
  endtask

  task automatic t_rail();
    for (int i = 0; i < 2; i++) begin
      wr(dil_pkg::SW_TRIGGER_IDX, 32'h0000_0003);
      codes(16'h0F0F, 16'hF0F0);
      if (i == 0) avddGood <= 1'b0;
      else dvddGood <= 1'b0;
      repeat (4) @(posedge mclk);
      codes(16'h0000, 16'h0000);
      avddGood <= 1'b1;
      dvddGood <= 1'b1;
      repeat (3) @(posedge mclk);
      rdchk(dil_pkg::CH0_STAGING_IDX, 32'h0000_0000, "rail reset");
      wr(dil_pkg::CH0_STAGING_IDX, 32'h000F_0F00);
      wr(dil_pkg::CH1_STAGING_IDX, 32'h00F0_F000);
    end
    $display("t_rail done");
  endtask

  // Auto transfer, active readback, refused writes and a single byte lane
  task automatic t_auto();
    logic [31:0] rd;
    rdchk(dil_pkg::CH0_ACTIVE_IDX, 32'h0000_0000, "ch0 active read");
    wr(dil_pkg::AUTO_CTRL_IDX, 32'h0000_0001);
    rdchk(dil_pkg::AUTO_CTRL_IDX, 32'h0000_0001, "auto enable");
    xfer(1'b1, dil_pkg::CH0_STAGING_IDX, 32'h00AB_CDEF, 4'h4, rd);
    @(posedge mclk);
    codes(16'hAB0F, 16'h0000);
    rdchk(dil_pkg::CH0_STAGING_IDX, 32'h00AB_0F00, "ch0 lane");
    rdchk(dil_pkg::CH0_ACTIVE_IDX, 32'h00AB_0F00, "ch0 active auto");
    wr(dil_pkg::CH0_ACTIVE_IDX, 32'h00FF_FF00);
    rdchk(dil_pkg::CH0_ACTIVE_IDX, 32'h00AB_0F00, "active write refused");
    wr(dil_pkg::AUTO_CTRL_IDX, 32'h0000_0000);
    wr(dil_pkg::CH1_STAGING_IDX, 32'h0012_3400);
    @(posedge mclk);
    codes(16'hAB0F, 16'h0000);
    rdchk(dil_pkg::CH1_ACTIVE_IDX, 32'h0000_0000, "ch1 no auto");
    $display("t_auto done");
  endtask

  // Main sequence; reset held 8 cycles, then 3 edges before traffic
  initial begin
    rstn = 1'b0;
    avddGood = 1'b1;
    dvddGood = 1'b1;
    hwLoadLineN = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 10'h000;
    wbSel = 4'hF;
    wbDatI = 32'h0000_0000;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_stage();
    t_swload();
    t_both();
    t_hw();
    t_rail();
    t_auto();
    stop_test();
  end
endmodule
